// ### common/cmr_pkg.sv
// Package for the CAN mode control and receive path block.
// Assumes a single 100 MHz clock and an APB register bus.
package cmr_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS    = 8'h04;
  localparam logic [7:0] FLAG_OFS    = 8'h08;
  localparam logic [7:0] ERRCNT_OFS  = 8'h0C;
  localparam logic [7:0] FIFO_OFS    = 8'h10;
  localparam logic [7:0] BUFDIR_OFS  = 8'h14;
  localparam logic [7:0] RXFULL_OFS  = 8'h18;
  localparam logic [7:0] TIMING_OFS  = 8'h1C;
  localparam logic [7:0] MASK0_OFS   = 8'h20;
  localparam logic [7:0] FILT0_OFS   = 8'h40;
  localparam logic [7:0] FCFG0_OFS   = 8'h80;
  // Control and timing register field positions
  localparam int REQ_LSB     = 8;
  localparam int CUR_LSB     = 5;
  localparam int WAKFLT_BIT  = 14;
  localparam int TX_REQUEST_BIT_BIT   = 0;
  // Flag register bit positions
  localparam int FL_RXBUF    = 1;
  localparam int FL_OVR      = 2;
  localparam int FL_ERR      = 5;
  localparam int FL_WAKE     = 6;
  localparam int FL_IVR      = 7;
  localparam int FL_RX_WARNING_FLAG    = 9;
  localparam int FL_RX_PASSIVE_FLAG     = 11;
  localparam int FL_TX_ABORT_FLAG    = 16;
  // Reset values
  localparam logic [2:0] MODE_RESET  = 3'h4;
  localparam logic [4:0] FSA_RESET   = 5'h00;
  localparam logic [2:0] AREA_RESET  = 3'h0;
  // Counts
  localparam int IDLE_BITS    = 11;
  localparam int WARN_LEVEL   = 96;
  localparam int PASSIVE_LVL  = 127;
  localparam int MAX_OVERLOAD = 2;
  localparam int FIFO_PTR     = 15;
  localparam logic [15:0] BIT_DIV_RESET = 16'h0064;
  localparam int WAKE_FILT_NS = 50;
  localparam int CLK_NS       = 10;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0, MODE_DISABLE = 3'h1, MODE_LOOPBACK = 3'h2,
    MODE_LISTEN = 3'h3, MODE_CONFIG = 3'h4, MODE_LISTEN_ALL = 3'h7
  } cmr_mode_type;

  // One frame from the assembly buffer
  typedef struct packed {
    logic        ext;
    logic [10:0] base_identifier;
    logic [17:0] extension_identifier;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cmr_frame_type;

  // Per-filter configuration
  typedef struct packed {
    logic       enable;
    logic       filter_extended_select;
    logic [1:0] filter_mask_select;
    logic [3:0] filter_buffer_pointer;
  } cmr_fcfg_type;
endpackage

// ### hw/cmr_core.sv
// CAN mode control and receive path: modes, idle detection, filters, buffers, rx errors.
// Assumes a protocol engine beside it that delivers bit ticks, tx bits, frame and error events.
//
// Contract
// (R1) Standard frames carry 11-bit base id; extended add 18-bit extension.
// (R2) At most 2 overload frames in a row.
// (R3) Mode request applied and reported only after bus idle of 11 recessive bits.
// (R4) Init mode: no tx or rx, clear error counters, keep flags.
// (R5) Config registers writable only in configuration mode.
// (R6) No entry to configuration mode while a transmission runs.
// (R7) Request 001 enters disable after idle, reports 001, releases pins.
// (R8) Disable: no tx/rx, wake flag still set, flags and counters kept.
// (R9) Wake filter enable low-pass filters the receive input while asleep.
// (R10) Disable during 11-bit wait aborts pending tx, sets abort, clears request.
// (R11) Request 000: normal mode, owns pins, sends and receives.
// (R12) Listen-only: passive, no error flags or acks, counters frozen, tx released.
// (R13) Request 111: ignore errors, accept all, store partial frame on error.
// (R14) Loopback: internal tx to internal rx, both pins released.
// (R15) 32 receive buffers, first 8 direction-selectable, first 16 filterable.
// (R16) Store only on filter match, set rx flag; hardware sets, software clears.
// (R17) Pointer 1111 stores to next free FIFO buffer from start to area end.
// (R18) 4-bit pointer picks buffer; filters match only same frame format.
// (R19) Zero mask bit matches anything; each filter picks one of three masks.
// (R20) Rx errors add one to counter; warning flag at 96.
// (R21) Counter above 127 sets error-passive flag.
// (R22) Rx flag after end of frame; per-buffer flag; overrun and invalid flags.
// (R23) Count recessive bits, restart on dominant, apply mode at threshold.
//
// Design decisions made here: the register offsets and register access over APB.
module cmr_core
  import cmr_pkg::*;
#(
  parameter int NUM_FILT = 16,
  parameter int NUM_BUF  = 32
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          bus_receive_pin,
  output logic               bus_transmit_pin,
  output logic               bus_transmit_oe,
  input  wire logic          sleep_req,
  input  wire logic          eng_tx_bit,
  input  wire logic          eng_tx_busy,
  input  wire logic          eng_bit_tick,
  input  wire logic          eng_frame_done,
  input  wire cmr_frame_type eng_frame,
  input  wire logic          eng_err_crc,
  input  wire logic          eng_err_stuff,
  input  wire logic          eng_err_form,
  input  wire logic          eng_overload_req,
  output logic               rx_bit,
  output logic               rx_enable,
  output logic               tx_enable,
  output logic               ack_enable,
  output logic               err_flag_enable,
  output logic               overload_grant,
  output logic               buf_we,
  output logic [4:0]         buf_index,
  output cmr_frame_type      buf_frame
);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]  mode_request_field;
  logic [2:0]  current_mode_field;
  logic        wake_filter_enable;
  logic        tx_request_bit;
  logic [31:0] flags;
  logic [7:0]  rx_error_counter;
  logic [4:0]  fifo_start_field;
  logic [2:0]  buffer_area_size;
  logic [7:0]  buffer_direction_select;
  logic [31:0] rx_full;
  logic [4:0]  fifo_next;
  logic [15:0] bit_timing;
  logic [28:0] mask [3];
  logic [28:0] filt [NUM_FILT];
  cmr_fcfg_type fcfg [NUM_FILT];
  logic [3:0]  idle_cnt;
  logic [1:0]  ovl_cnt;
  logic        rx_s1, rx_s2;
  logic [3:0]  wake_cnt;
  logic        rx_filt, rx_prev;
  logic        cfg_mode, wr, rd, asleep, rd_ready;

  assign cfg_mode = current_mode_field == MODE_CONFIG;
  assign wr       = psel && penable && pwrite;
  assign rd       = psel && penable && !pwrite;
  // Reads take one wait state so prdata comes from a flop and stands with pready
  assign pready   = pwrite || rd_ready;
  assign pslverr  = 1'b0;
  assign asleep   = sleep_req || current_mode_field == MODE_DISABLE;

  // Masked compare, zero mask bit matches
  function automatic logic id_match(input logic [28:0] id, input logic [28:0] f,
                                    input logic [28:0] m);
    return ((id ^ f) & m) == 29'h0;
  endfunction

  function automatic logic [28:0] frame_id(input cmr_frame_type fr);
    // (R1) id width by format
    return fr.ext ? {fr.base_identifier, fr.extension_identifier}
                  : {fr.base_identifier, 18'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser and wake filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= bus_receive_pin;
      rx_s2 <= rx_s1;
    end
  end

  // (R9) low-pass while asleep
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_cnt <= 4'h0;
      rx_filt  <= 1'b1;
    end else if (!(wake_filter_enable && asleep) || rx_s2 == rx_filt) begin
      wake_cnt <= 4'h0;
      rx_filt  <= rx_s2;
    end else if (wake_cnt == 4'(WAKE_FILT_CYC - 1)) begin
      wake_cnt <= 4'h0;
      rx_filt  <= rx_s2;
    end else begin
      wake_cnt <= wake_cnt + 4'h1;
    end
  end

  // (R14) loopback routes internal tx to rx
  always_comb begin
    if (current_mode_field == MODE_LOOPBACK)
      rx_bit = eng_tx_bit;
    else
      rx_bit = rx_s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // (R23) idle bit counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      idle_cnt <= 4'h0;
    else if (eng_bit_tick) begin
      if (!rx_bit)
        idle_cnt <= 4'h0;
      else if (idle_cnt != 4'(IDLE_BITS))
        idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // (R3) mode switch at idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      current_mode_field <= MODE_RESET;
    else if (mode_request_field != current_mode_field && idle_cnt == 4'(IDLE_BITS)) begin
      // (R6) config waits for tx end
      if (!(mode_request_field == MODE_CONFIG && eng_tx_busy))
        current_mode_field <= mode_request_field;
    end
  end

  // (R11) (R12) (R14) (R7) pin ownership and path enables
  always_comb begin
    tx_enable       = current_mode_field == MODE_NORMAL ||
                      current_mode_field == MODE_LOOPBACK;
    rx_enable       = !(current_mode_field == MODE_CONFIG ||
                        current_mode_field == MODE_DISABLE);
    ack_enable      = current_mode_field == MODE_NORMAL;
    err_flag_enable = current_mode_field == MODE_NORMAL;
    bus_transmit_oe = current_mode_field == MODE_NORMAL;
    bus_transmit_pin = bus_transmit_oe ? eng_tx_bit : 1'b1;
  end

  // (R2) overload frame limit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ovl_cnt <= 2'h0;
    else if (eng_frame_done)
      ovl_cnt <= 2'h0;
    else if (eng_overload_req && overload_grant)
      ovl_cnt <= ovl_cnt + 2'h1;
  end
  assign overload_grant = ack_enable && ovl_cnt < 2'(MAX_OVERLOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance
  logic        hit;
  logic [3:0]  hit_ptr;
  logic        any_err, accept_all;
  logic [4:0]  tgt;
  logic        store;
  logic [4:0]  area_end;

  assign any_err    = eng_err_crc || eng_err_stuff || eng_err_form;
  assign accept_all = current_mode_field == MODE_LISTEN_ALL;
  assign area_end   = 5'((6'h1 << buffer_area_size) * 6'h4 > 6'd32 ? 6'd31 :
                         (6'h1 << buffer_area_size) * 6'h4 - 6'h1);

  always_comb begin
    hit     = 1'b0;
    hit_ptr = 4'h0;
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      // (R18) (R19) format and mask compare
      if (fcfg[i].enable && fcfg[i].filter_extended_select == eng_frame.ext &&
          fcfg[i].filter_mask_select != 2'h3 &&
          id_match(frame_id(eng_frame), filt[i], mask[fcfg[i].filter_mask_select])) begin
        hit     = 1'b1;
        hit_ptr = fcfg[i].filter_buffer_pointer;
      end
    end
    // (R17) FIFO pointer goes to next free slot
    tgt = (hit_ptr == 4'(FIFO_PTR) || accept_all && !hit) ? fifo_next : {1'b0, hit_ptr};
    // (R15) first 8 must be clear to receive
    store = rx_enable && (hit || accept_all) &&
            !(tgt < 5'h8 && buffer_direction_select[tgt[2:0]]);
  end

  // (R13) partial frame stored on error in listen-all
  logic do_store;
  assign do_store  = store && (eng_frame_done || accept_all && any_err);
  assign buf_we    = do_store && !rx_full[tgt];
  assign buf_index = tgt;
  assign buf_frame = eng_frame;

  // FIFO next pointer wraps from area end back to start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      fifo_next <= FSA_RESET;
    else if (cfg_mode)
      fifo_next <= fifo_start_field;
    else if (buf_we && tgt == fifo_next)
      fifo_next <= (fifo_next >= area_end) ? fifo_start_field : fifo_next + 5'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // (R20) (R21) (R4) (R12) rx error counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rx_error_counter <= 8'h00;
    else if (cfg_mode)
      rx_error_counter <= 8'h00;
    else if (any_err && err_flag_enable && rx_error_counter != 8'hFF)
      rx_error_counter <= rx_error_counter + 8'h01;
  end

  // Flags: hardware set wins over a clearing write
  logic [31:0] set_f, clr_f;
  logic        tx_abort;
  // (R10) disable during idle wait aborts tx
  assign tx_abort = tx_request_bit && mode_request_field == MODE_DISABLE &&
                    !eng_tx_busy && idle_cnt != 4'(IDLE_BITS);
  always_comb begin
    set_f = 32'h0;
    // (R16) (R22) rx flag at frame end
    set_f[FL_RXBUF] = buf_we;
    set_f[FL_OVR]   = do_store && rx_full[tgt];
    set_f[FL_IVR]   = any_err && rx_enable;
    set_f[FL_RX_WARNING_FLAG] = rx_error_counter >= 8'(WARN_LEVEL);
    set_f[FL_RX_PASSIVE_FLAG]  = rx_error_counter > 8'(PASSIVE_LVL);
    set_f[FL_ERR]   = set_f[FL_OVR] || set_f[FL_IVR] ||
                      (rx_error_counter == 8'(WARN_LEVEL - 1) && any_err);
    // (R8) wake on activity while disabled
    set_f[FL_WAKE]  = current_mode_field == MODE_DISABLE && rx_prev && !rx_filt;
    set_f[FL_TX_ABORT_FLAG] = tx_abort;
    clr_f = (wr && paddr == FLAG_OFS) ? pwdata : 32'h0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags   <= 32'h0;
      rx_prev <= 1'b1;
    end else begin
      flags   <= (flags & ~clr_f) | set_f;
      rx_prev <= rx_filt;
    end
  end

  // Per-buffer full flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rx_full <= 32'h0;
    else
      rx_full <= (rx_full & ~((wr && paddr == RXFULL_OFS) ? pwdata : 32'h0)) |
                 (buf_we ? 32'h1 << tgt : 32'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_request_field      <= MODE_RESET;
      tx_request_bit          <= 1'b0;
      wake_filter_enable      <= 1'b0;
      fifo_start_field        <= FSA_RESET;
      buffer_area_size        <= AREA_RESET;
      buffer_direction_select <= 8'h00;
      bit_timing              <= BIT_DIV_RESET;
      for (int i = 0; i < 3; i++) mask[i] <= 29'h0;
      for (int i = 0; i < NUM_FILT; i++) begin
        filt[i] <= 29'h0;
        fcfg[i] <= '0;
      end
    end else begin
      if (tx_abort)
        tx_request_bit <= 1'b0;
      if (wr && paddr == CTRL_OFS) begin
        mode_request_field <= pwdata[REQ_LSB +: 3];
        if (!tx_abort)
          tx_request_bit <= pwdata[TX_REQUEST_BIT_BIT];
      end
      // (R5) config-only writes
      if (wr && cfg_mode) begin
        if (paddr == TIMING_OFS) begin
          bit_timing         <= pwdata[15:0];
          wake_filter_enable <= pwdata[WAKFLT_BIT];
        end
        if (paddr == FIFO_OFS) begin
          fifo_start_field <= pwdata[4:0];
          buffer_area_size <= pwdata[15:13];
        end
        if (paddr == BUFDIR_OFS)
          buffer_direction_select <= pwdata[7:0];
        for (int i = 0; i < 3; i++)
          if (paddr == MASK0_OFS + 8'(4 * i)) mask[i] <= pwdata[28:0];
        for (int i = 0; i < NUM_FILT; i++) begin
          if (paddr == FILT0_OFS + 8'(4 * i)) filt[i] <= pwdata[28:0];
          if (paddr == FCFG0_OFS + 8'(4 * i)) fcfg[i] <= pwdata[7:0];
        end
      end
    end
  end

  // Read wait state: data loaded in the first access cycle, ready in the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rd_ready <= 1'b0;
    else
      rd_ready <= rd && !rd_ready;
  end

  // Register reads, unmapped reads as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      prdata <= 32'h0;
    else if (rd && !rd_ready) begin
      prdata <= 32'h0;
      unique case (paddr)
        CTRL_OFS:   prdata <= {21'h0, mode_request_field, current_mode_field, 4'h0,
                               tx_request_bit};
        FLAG_OFS:   prdata <= flags;
        ERRCNT_OFS: prdata <= {24'h0, rx_error_counter};
        FIFO_OFS:   prdata <= {16'h0, buffer_area_size, 3'h0, fifo_next, 5'h0};
        RXFULL_OFS: prdata <= rx_full;
        TIMING_OFS: prdata <= {16'h0, wake_filter_enable, bit_timing[14:0]};
        default:    prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_mode_idle;
    @(posedge clk) disable iff (!reset_n)
      current_mode_field != $past(current_mode_field) |-> $past(idle_cnt) == 4'(IDLE_BITS);
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode changed off idle"); // (R3)
  property p_cfg_clear;
    @(posedge clk) disable iff (!reset_n) cfg_mode |=> rx_error_counter == 8'h00;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("counter not cleared"); // (R4)
  property p_lock;
    @(posedge clk) disable iff (!reset_n)
      !cfg_mode && !$past(cfg_mode) ##0 $stable(cfg_mode) |-> $stable(buffer_area_size);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed"); // (R5)
  property p_no_cfg_tx;
    @(posedge clk) disable iff (!reset_n)
      $rose(cfg_mode) |-> !$past(eng_tx_busy);
  endproperty
  a_no_cfg_tx: assert property (p_no_cfg_tx) else $error("config during tx"); // (R6)
  property p_listen;
    @(posedge clk) disable iff (!reset_n)
      current_mode_field == MODE_LISTEN |-> !bus_transmit_oe && !ack_enable ##1
      rx_error_counter == $past(rx_error_counter);
  endproperty
  a_listen: assert property (p_listen) else $error("listen not passive"); // (R12)
  property p_ovl;
    @(posedge clk) disable iff (!reset_n) ovl_cnt <= 2'(MAX_OVERLOAD);
  endproperty
  a_ovl: assert property (p_ovl) else $error("too many overloads"); // (R2)
  property p_store;
    @(posedge clk) disable iff (!reset_n) buf_we |=> flags[FL_RXBUF] && rx_full[$past(tgt)];
  endproperty
  a_store: assert property (p_store) else $error("store flag missing"); // (R16)
  property p_warn;
    @(posedge clk) disable iff (!reset_n) rx_error_counter >= 8'(WARN_LEVEL) |=> flags[FL_RX_WARNING_FLAG];
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag missing"); // (R20)
  property p_passive;
    @(posedge clk) disable iff (!reset_n) rx_error_counter > 8'(PASSIVE_LVL) |=> flags[FL_RX_PASSIVE_FLAG];
  endproperty
  a_passive: assert property (p_passive) else $error("passive flag missing"); // (R21)
  property p_abort;
    @(posedge clk) disable iff (!reset_n) tx_abort |=> !tx_request_bit && flags[FL_TX_ABORT_FLAG];
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken"); // (R10)
endmodule

// ### sim/cmr_node_model.sv
// Far-side CAN node model: receive line, bit ticks, frames and receive errors.
// Assumes one clock; a bit lasts five clocks, its tick in the fourth one.
module cmr_node_model
  import cmr_pkg::*;
(
  input  wire logic     clk,
  output logic          rx_line,
  output logic          tick,
  output logic          frame_done,
  output cmr_frame_type frame,
  output logic [2:0]    errs
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_line    = 1'h1;
    tick       = 1'h0;
    frame_done = 1'h0;
    frame      = '0;
    errs       = 3'h0;
  end
  ////////////////////////////////////////
  // Released bus returns to recessive, never holds the last level
  task automatic bits(input logic lvl, input int n);
    repeat (n) begin
      @(posedge clk);
      rx_line <= lvl;
      repeat (3) @(posedge clk);
      tick <= 1'h1;
      @(posedge clk);
      tick <= 1'h0;
    end
    rx_line <= 1'h1;
  endtask
  // whole frame, extension included, with frame_done for one cycle
  task automatic send(input cmr_frame_type f);
    @(posedge clk);
    frame      <= f;
    frame_done <= 1'h1;
    @(posedge clk);
    frame_done <= 1'h0;
    frame      <= ~f;
  endtask
  // Rotates crc, stuffing and form errors
  task automatic err(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      errs <= 3'h1 << (i % 3);
      @(posedge clk);
      errs <= 3'h0;
    end
  endtask
endmodule

// ### sim/can_mode_and_receive_path_test.sv
// Self-checking bench for the CAN mode control and receive path.
// Assumes cmr_core, the node model as far side and an APB master here.
module can_mode_and_receive_path_test
  import cmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic          eng_tx_busy = 1'h0, tx_flip = 1'h0, ovl_req = 1'h0, ovl_gnt;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, prdata, rd;
  logic          pready, pslverr, tx_pin, tx_oe, rx_line, tick, fdone, rx_bit;
  logic          rx_en, tx_en, ack_en, errf_en, buf_we;
  logic [2:0]    errs;
  logic [4:0]    buf_index, last_idx;
  logic [10:0]   last_base;
  cmr_frame_type frame, buf_frame;
  int            mismatches = 0, n_checks = 0, cycles = 0, we_cnt = 0;
  wire logic     eng_tx_bit = rx_line ^ tx_flip;

  always #5 clk = ~clk;
  cmr_node_model node (.clk(clk), .rx_line(rx_line), .tick(tick), .frame_done(fdone),
    .frame(frame), .errs(errs));
  cmr_core DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_receive_pin(rx_line), .bus_transmit_pin(tx_pin),
    .bus_transmit_oe(tx_oe), .sleep_req(1'h0), .eng_tx_bit(eng_tx_bit),
    .eng_tx_busy(eng_tx_busy), .eng_bit_tick(tick), .eng_frame_done(fdone),
    .eng_frame(frame), .eng_err_crc(errs[0]), .eng_err_stuff(errs[1]),
    .eng_err_form(errs[2]), .eng_overload_req(ovl_req), .rx_bit(rx_bit), .rx_enable(rx_en),
    .tx_enable(tx_en), .ack_enable(ack_en), .err_flag_enable(errf_en),
    .overload_grant(ovl_gnt), .buf_we(buf_we), .buf_index(buf_index), .buf_frame(buf_frame));
  ////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (buf_we === 1'h1) begin
      we_cnt++;
      last_idx  = buf_index;
      last_base = buf_frame.base_identifier;
    end
    if (cycles == 20000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Request held until pready is seen high; read data taken at that same edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  // A dominant bit first restarts the idle count
  task automatic set_mode(input cmr_mode_type m, input cmr_mode_type old);
    node.bits(1'h0, 1);
    apb(1'h1, CTRL_OFS, 32'(m) << REQ_LSB);
    node.bits(1'h1, 10);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(32'(rd[CUR_LSB +: 3]), 32'(old), "mode before idle");
    node.bits(1'h1, 1);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(32'(rd[CUR_LSB +: 3]), 32'(m), "mode after idle");
  endtask
  task automatic send_frame(input logic ext, input logic [10:0] id, input logic [4:0] idx);
    cmr_frame_type f;
    f = '0;
    f.ext = ext;
    f.base_identifier = id;
    f.extension_identifier = 18'h2AAAA;
    we_cnt = 0;
    node.send(f);
    for (int i = 0; i < 8 && we_cnt == 0; i++) @(posedge clk);
    chk(32'(we_cnt), 32'h1, "store count");
    chk(32'(last_idx), 32'(idx), "store index");
    chk(32'(last_base), 32'(id), "stored id");
  endtask
  task automatic cnt_flags(input int n, input logic [7:0] cnt, input logic w, input logic p);
    node.err(n);
    apb(1'h0, ERRCNT_OFS, 32'h0);
    chk(32'(rd[7:0]), 32'(cnt), "rx error count");
    apb(1'h0, FLAG_OFS, 32'h0);
    chk(32'({rd[FL_RX_WARNING_FLAG], rd[FL_RX_PASSIVE_FLAG]}), 32'({w, p}), "warn, passive");
  endtask
  ////////////////////////////////////////
  task automatic t_reset_filters();
    logic [31:0] keep;
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(32'(rd[CUR_LSB +: 3]), 32'(MODE_RESET), "reset mode");
    chk(32'({tx_oe, tx_pin, pslverr}), 32'h2, "reset pins");
    apb(1'h1, MASK0_OFS, 32'h0);
    apb(1'h1, FCFG0_OFS, 32'h85);
    apb(1'h1, FCFG0_OFS + 8'h04, 32'hC6);
    set_mode(MODE_NORMAL, MODE_CONFIG);
    chk(32'({tx_oe, rx_en, tx_en}), 32'h7, "normal pins");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      chk(32'(ovl_gnt), 32'(i < MAX_OVERLOAD), "overload grant");
      ovl_req <= 1'h1;
      @(posedge clk);
      ovl_req <= 1'h0;
    end
    apb(1'h0, TIMING_OFS, 32'h0);
    keep = rd;
    apb(1'h1, TIMING_OFS, ~keep);
    apb(1'h0, TIMING_OFS, 32'h0);
    chk(rd, keep, "locked write");
    send_frame(1'h0, 11'h5A5, 5'h05);
    send_frame(1'h1, 11'h31C, 5'h06);
    apb(1'h0, FLAG_OFS, 32'h0);
    chk(32'(rd[FL_RXBUF]), 32'h1, "rx flag set");
    apb(1'h1, FLAG_OFS, 32'h1 << FL_RXBUF);
    apb(1'h0, FLAG_OFS, 32'h0);
    chk(32'(rd[FL_RXBUF]), 32'h0, "rx flag cleared");
    apb(1'h0, 8'hFC, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask
  task automatic t_modes();
    set_mode(MODE_LISTEN, MODE_NORMAL);
    chk(32'({tx_oe, ack_en, errf_en}), 32'h0, "listen passive");
    node.err(2);
    apb(1'h0, ERRCNT_OFS, 32'h0);
    chk(32'(rd[7:0]), 32'h0, "frozen count");
    set_mode(MODE_LOOPBACK, MODE_LISTEN);
    @(posedge clk);
    tx_flip <= 1'h1;
    @(negedge clk);
    chk(32'({rx_bit, tx_oe}), 32'h0, "loopback route");
    @(posedge clk);
    tx_flip <= 1'h0;
    set_mode(MODE_LISTEN_ALL, MODE_LOOPBACK);
    apb(1'h1, RXFULL_OFS, 32'h20);
    we_cnt = 0;
    node.err(1);
    @(posedge clk);
    chk(32'({we_cnt, last_idx}), 32'h25, "partial frame stored");
    set_mode(MODE_DISABLE, MODE_LISTEN_ALL);
    chk(32'({rx_en, tx_en, tx_oe}), 32'h0, "disabled");
  endtask
  task automatic t_errors();
    set_mode(MODE_NORMAL, MODE_DISABLE);
    cnt_flags(95, 8'h5F, 1'h0, 1'h0);
    cnt_flags(1, 8'h60, 1'h1, 1'h0);
    cnt_flags(31, 8'h7F, 1'h1, 1'h0);
    cnt_flags(1, 8'h80, 1'h1, 1'h1);
    @(posedge clk);
    eng_tx_busy <= 1'h1;
    node.bits(1'h0, 1);
    apb(1'h1, CTRL_OFS, 32'(MODE_CONFIG) << REQ_LSB);
    node.bits(1'h1, 12);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(32'(rd[CUR_LSB +: 3]), 32'(MODE_NORMAL), "config held off");
    @(posedge clk);
    eng_tx_busy <= 1'h0;
    node.bits(1'h1, 1);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(32'(rd[CUR_LSB +: 3]), 32'(MODE_CONFIG), "config entered");
    apb(1'h0, ERRCNT_OFS, 32'h0);
    chk(32'(rd[7:0]), 32'h0, "counter cleared");
    apb(1'h0, FLAG_OFS, 32'h0);
    chk(32'(rd[FL_RX_WARNING_FLAG]), 32'h1, "flags kept");
    node.bits(1'h0, 1);
    apb(1'h1, CTRL_OFS, (32'(MODE_DISABLE) << REQ_LSB) | 32'h1);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(32'(rd[TX_REQUEST_BIT_BIT]), 32'h0, "abort clears request");
    apb(1'h0, FLAG_OFS, 32'h0);
    chk(32'(rd[FL_TX_ABORT_FLAG]), 32'h1, "abort flag");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    t_reset_filters();
    t_modes();
    t_errors();
    end_sim();
  end
endmodule
